// ### core/fcl_fault_bank.sv
// fault current limit register bank with lock detection and apb access
`timescale 1ns/1ps
`default_nettype none
module fcl_fault_bank import fcl_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// current samples for the two lock paths
	input wire fcl_sample_s cmp_sample,
	input wire fcl_sample_s adc_sample,
	// non-volatile memory fault event, one-cycle pulse
	input wire logic nvm_fault_evt,
	// results
	output logic [3:0] iq_limit_code,
	output logic nvm_fault_latched,
	output logic irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	fcl_settings_s settings_reg;
	logic [FCL_ST_W-1:0] status_reg;
	logic [FCL_ST_W-1:0] status_next;
	logic [FCL_ST_W-1:0] mask_reg;
	logic [FCL_ST_W-1:0] mask_next;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic irq_reg;
	logic nvm_latch_reg;
	logic nvm_latch_next;
	logic [3:0] iq_limit_reg;
	logic [3:0] iq_limit_next;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	localparam int FCL_STAT_PAD = 32 - FCL_ST_W;

	// setup is the first cycle, access completes with pready one cycle later
	wire logic setup_phase;
	wire logic access_done;
	wire logic hit_settings;
	wire logic hit_status;
	wire logic hit_mask;
	wire logic hit_any;
	wire logic wr_done;
	wire logic [31:0] rd_word;
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign hit_settings = paddr == FCL_ADDR_SETTINGS;
	assign hit_status = paddr == FCL_ADDR_STATUS;
	assign hit_mask = paddr == FCL_ADDR_MASK;
	assign hit_any = hit_settings || hit_status || hit_mask;
	assign wr_done = access_done && pwrite && hit_any;

	// read mux, unmapped reads return zero with an error
	assign rd_word = hit_settings ? settings_reg :
		hit_status ? {{FCL_STAT_PAD{1'b0}}, status_reg} :
		hit_mask ? {{FCL_STAT_PAD{1'b0}}, mask_reg} : 32'h0000_0000;

	// ---------------------------------------------------------------
	// lock detection paths
	// ---------------------------------------------------------------
	wire logic [3:0] path_thr [FCL_NUM_PATHS];
	wire fcl_sample_s path_sample [FCL_NUM_PATHS];
	wire logic [FCL_NUM_PATHS-1:0] path_lock;
	assign path_thr[0] = settings_reg.comparator_lock_threshold;
	assign path_thr[1] = settings_reg.adc_lock_threshold;
	assign path_sample[0] = cmp_sample;
	assign path_sample[1] = adc_sample;

	// one comparator per path, identical logic
	genvar g;
	generate
		for (g = 0; g < FCL_NUM_PATHS; g++) begin : gen_path
			fcl_lock_cmp fcl_lock_cmp_inst (
				.mclk(mclk),
				.rst_n(rst_n),
				.threshold(path_thr[g]),
				.sample(path_sample[g]),
				.lock_pulse(path_lock[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// status, mask and fault response
	// ---------------------------------------------------------------
	wire logic [FCL_ST_W-1:0] st_events;
	wire logic [FCL_ST_W-1:0] st_w1c;
	wire logic nvm_latch_set;
	assign st_events = {nvm_fault_evt, path_lock[1], path_lock[0]};
	assign st_w1c = (wr_done && hit_status) ? pwdata[FCL_ST_W-1:0] : FCL_ST_RST;

	// a new event in the clearing cycle survives the clear
	assign status_next = (status_reg & ~st_w1c) | st_events;
	assign mask_next = (wr_done && hit_mask) ? pwdata[FCL_ST_W-1:0] : mask_reg;

	// latched mode holds the fault until software clears the status bit
	assign nvm_latch_set = nvm_fault_evt
		&& (settings_reg.nvm_fault_response == FCL_NVM_LATCHED);
	assign nvm_latch_next = nvm_latch_set
		|| (nvm_latch_reg && !st_w1c[FCL_ST_NVM]);

	// undefined limit codes fall back to the top defined current
	assign iq_limit_next = fcl_code_valid(settings_reg.iq_limit) ?
		settings_reg.iq_limit : FCL_CODE_MAX;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// configuration word, all 32 bits kept for read-back
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			settings_reg <= FCL_SETTINGS_RST;
		end else if (wr_done && hit_settings) begin
			settings_reg <= fcl_settings_s'(pwdata);
		end
	end

	// status, mask and derived outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= FCL_ST_RST;
			mask_reg <= FCL_ST_RST;
			irq_reg <= 1'b0;
			nvm_latch_reg <= 1'b0;
			iq_limit_reg <= FCL_SETTINGS_RST[FCL_IQ_LIM_LSB +: 4];
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= |(status_next & mask_next); // tracks status with no lag
			nvm_latch_reg <= nvm_latch_next;
			iq_limit_reg <= iq_limit_next;
		end
	end

	// bus answer: zero wait states, pready in the first access cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup_phase;
			prdata_reg <= setup_phase ? rd_word : 32'h0000_0000;
			pslverr_reg <= setup_phase && !hit_any;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign nvm_fault_latched = nvm_latch_reg;
	assign iq_limit_code = iq_limit_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// a defined limit code reaches the output one cycle later
	a_iq_limit_pass: assert property (@(posedge mclk) disable iff (!rst_n)
		fcl_code_valid(settings_reg.iq_limit) |=> iq_limit_code == $past(settings_reg.iq_limit))
		else $error("torque limit code not passed through");

	// an undefined limit code never leaves the block
	a_iq_limit_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
		!fcl_code_valid(settings_reg.iq_limit) |=> iq_limit_code == FCL_CODE_MAX)
		else $error("torque limit code not clamped");

	// comparator overcurrent sets its status bit two cycles later
	a_cmp_lock_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		cmp_sample.valid && fcl_code_valid(settings_reg.comparator_lock_threshold)
		&& cmp_sample.magnitude > settings_reg.comparator_lock_threshold
		|=> ##1 status_reg[FCL_ST_CMP])
		else $error("comparator lock not flagged");

	// converter overcurrent sets its status bit two cycles later
	a_adc_lock_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		adc_sample.valid && fcl_code_valid(settings_reg.adc_lock_threshold)
		&& adc_sample.magnitude > settings_reg.adc_lock_threshold
		|=> ##1 status_reg[FCL_ST_ADC])
		else $error("converter lock not flagged");

	// no comparator lock flagged while current stays at or under the threshold
	a_no_false_lock: assert property (@(posedge mclk) disable iff (!rst_n)
		!(cmp_sample.valid && cmp_sample.magnitude > settings_reg.comparator_lock_threshold)
		&& $stable(settings_reg) |=> !path_lock[0])
		else $error("comparator lock without overcurrent");

	// latched mode holds the fault, report mode only raises status
	a_nvm_latch_mode: assert property (@(posedge mclk) disable iff (!rst_n)
		nvm_fault_evt && settings_reg.nvm_fault_response == FCL_NVM_LATCHED
		|=> nvm_fault_latched && status_reg[FCL_ST_NVM])
		else $error("nvm fault not latched");

	a_nvm_report_only: assert property (@(posedge mclk) disable iff (!rst_n)
		nvm_fault_evt && settings_reg.nvm_fault_response == FCL_NVM_REPORT
		&& !nvm_fault_latched |=> !nvm_fault_latched && status_reg[FCL_ST_NVM])
		else $error("report-only nvm fault latched");

	// clearing the fault bit drops the latch too, unless a new fault arrives
	a_nvm_w1c_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_done && hit_status && pwdata[FCL_ST_NVM] && !nvm_fault_evt
		|=> !status_reg[FCL_ST_NVM] && !nvm_fault_latched)
		else $error("nvm fault bit not cleared");

	// a fault in the clearing cycle wins over the clear
	a_nvm_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
		nvm_fault_evt |=> status_reg[FCL_ST_NVM])
		else $error("nvm fault event lost");

	// interrupt is high exactly while an unmasked status bit is set
	a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
		irq == |(status_reg & mask_reg))
		else $error("interrupt level does not match status");

	// every setup cycle is answered in the next cycle, for one cycle only
	a_apb_ready: assert property (@(posedge mclk) disable iff (!rst_n)
		psel && !penable |=> pready ##1 !pready)
		else $error("bus ready not a single-cycle answer");

	// unmapped addresses answer with an error and zero data
	a_unmapped_err: assert property (@(posedge mclk) disable iff (!rst_n)
		psel && !penable && !hit_any |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

endmodule
`default_nettype wire

// ### core/fcl_lock_cmp.sv
// one lock-detection comparator: flags current above its threshold code
`timescale 1ns/1ps
`default_nettype none
module fcl_lock_cmp import fcl_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// threshold and measured current
	input wire logic [3:0] threshold,
	input wire fcl_sample_s sample,
	// lock pulse, high one cycle per over-limit sample cycle
	output logic lock_pulse
);

	// an undefined threshold code never flags, so a bad write cannot fake a lock
	wire logic over_limit;
	assign over_limit = sample.valid && fcl_code_valid(threshold)
		&& (sample.magnitude > threshold);

	// registered so the status logic sees a clean pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lock_pulse <= 1'b0;
		end else begin
			lock_pulse <= over_limit;
		end
	end

endmodule
`default_nettype wire

// ### core/fcl_pkg.sv
// constants, types and helpers shared by the fault current limit register bank
//
// Overview of operation
// - Bits 30-27 cap the torque current, 0h = 0.078 A up to Dh = 3.75 A, Eh-Fh unused.
// - Bits 26-23 set the comparator lock current threshold on that scale, Eh-Fh undefined.
// - Bits 22-19 set the converter-sample lock current threshold, valid only for 0h-Dh.
// - Bit 18 picks the non-volatile memory fault response: zero latches, one only reports.
package fcl_pkg;

	// ---------------------------------------------------------------
	// register map (printed offsets are word indices)
	// ---------------------------------------------------------------
	localparam logic [11:0] FCL_IDX_SETTINGS = 12'h090;
	localparam logic [11:0] FCL_IDX_STATUS = 12'h0A0;
	localparam logic [11:0] FCL_IDX_MASK = 12'h0A1;
	localparam logic [11:0] FCL_ADDR_SETTINGS = {FCL_IDX_SETTINGS[9:0], 2'b00};
	localparam logic [11:0] FCL_ADDR_STATUS = {FCL_IDX_STATUS[9:0], 2'b00};
	localparam logic [11:0] FCL_ADDR_MASK = {FCL_IDX_MASK[9:0], 2'b00};

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int FCL_PARITY_BIT = 31;
	localparam int FCL_IQ_LIM_LSB = 27;
	localparam int FCL_CMP_THR_LSB = 23;
	localparam int FCL_ADC_THR_LSB = 19;
	localparam int FCL_NVM_RESP_BIT = 18;
	localparam logic [31:0] FCL_SETTINGS_RST = 32'h0000_0000;
	localparam logic FCL_NVM_LATCHED = 1'h0;
	localparam logic FCL_NVM_REPORT = 1'h1;

	// highest code with a defined current (3.75 A)
	localparam logic [3:0] FCL_CODE_MAX = 4'hD;

	// status / mask bit layout
	localparam int FCL_ST_CMP = 0;
	localparam int FCL_ST_ADC = 1;
	localparam int FCL_ST_NVM = 2;
	localparam int FCL_ST_W = 3;
	localparam logic [FCL_ST_W-1:0] FCL_ST_RST = 3'h0;
	localparam int FCL_NUM_PATHS = 2;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic parity;
		logic [3:0] iq_limit;
		logic [3:0] comparator_lock_threshold;
		logic [3:0] adc_lock_threshold;
		logic nvm_fault_response;
		logic [17:0] lower_fields;
	} fcl_settings_s;

	// one current sample on the lock-detection code scale
	typedef struct packed {
		logic valid;
		logic [3:0] magnitude;
	} fcl_sample_s;

	// codes Eh and Fh carry no current value
	function automatic logic fcl_code_valid(input logic [3:0] code);
		return code <= FCL_CODE_MAX;
	endfunction

endpackage

// ### verif/fcl_fault_bank_tb_top.sv
// self-checking bench for the fault current limit register bank
`timescale 1ns/1ps
`default_nettype none
module fcl_fault_bank_tb_top import fcl_pkg::*; ;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, nvm_fault_evt;
	logic nvm_fault_latched, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] iq_limit_code;
	fcl_sample_s cmp_sample, adc_sample;
	int miscompares, comparisons, cycles;

	fcl_fault_bank fcl_fault_bank_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .cmp_sample(cmp_sample),
		.adc_sample(adc_sample), .nvm_fault_evt(nvm_fault_evt),
		.iq_limit_code(iq_limit_code), .nvm_fault_latched(nvm_fault_latched), .irq(irq));

	// ---------------------------------------------------------------
	// clock, hang guard and verdict
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// the whole run needs well under a thousand cycles, so this only trips on a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ---------------------------------------------------------------
	// apb master: request held until pready is seen high at an edge
	// ---------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no cycle count assumed: pready ends this wait, and only the bench timeout catches a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, experr});
	endtask

	// one sample on a path; status is sticky, so it is read after the fact
	task automatic lock_try(input logic path, input logic [3:0] thr, input logic [3:0] mag,
		input logic hit);
		apb(1'b1, FCL_ADDR_SETTINGS, path ? {9'h0, thr, 19'h0} : {5'h0, thr, 23'h0});
		@(posedge mclk);
		if (path)
			adc_sample <= '{1'b1, mag};
		else
			cmp_sample <= '{1'b1, mag};
		@(posedge mclk);
		cmp_sample <= '0;
		adc_sample <= '0;
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, irq}, {31'h0, hit});
		rdchk(FCL_ADDR_STATUS, hit ? (path ? 32'h2 : 32'h1) : 32'h0, 1'b0);
		apb(1'b1, FCL_ADDR_STATUS, 32'h3);
		rdchk(FCL_ADDR_STATUS, 32'h0, 1'b0);
	endtask

	task automatic nvm_pulse;
		@(posedge mclk);
		nvm_fault_evt <= 1'b1;
		@(posedge mclk);
		nvm_fault_evt <= 1'b0;
		#1;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, nvm_fault_evt} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cmp_sample = '0;
		adc_sample = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		// reset values and outputs
		rdchk(FCL_ADDR_SETTINGS, FCL_SETTINGS_RST, 1'b0);
		rdchk(FCL_ADDR_STATUS, 32'h0, 1'b0);
		rdchk(FCL_ADDR_MASK, 32'h0, 1'b0);
		#1 chk({28'h0, iq_limit_code}, 32'h0);
		chk({30'h0, nvm_fault_latched, irq}, 32'h0);
		// full-word read back, unmapped and misaligned places refused
		apb(1'b1, FCL_ADDR_SETTINGS, 32'hA5A5_5A5A);
		rdchk(FCL_ADDR_SETTINGS, 32'hA5A5_5A5A, 1'b0);
		apb(1'b1, 12'h000, 32'h1234_5678);
		rdchk(12'h000, 32'h0, 1'b1);
		rdchk(12'h241, 32'h0, 1'b1);
		rdchk(FCL_ADDR_SETTINGS, 32'hA5A5_5A5A, 1'b0);
		apb(1'b1, FCL_ADDR_MASK, 32'hFFFF_FFFF);
		rdchk(FCL_ADDR_MASK, 32'h7, 1'b0);
		// every current cap code, the two unused ones clamped
		// the output flop loads on the edge after the write, so look just past it
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, FCL_ADDR_SETTINGS, {1'b0, c[3:0], 27'h0});
			@(posedge mclk);
			#1 chk({28'h0, iq_limit_code}, (c > FCL_CODE_MAX) ? {28'h0, FCL_CODE_MAX} : c);
		end
		// both lock paths: equal, just over, top code, undefined threshold
		for (int p = 0; p < 2; p++) begin
			lock_try(p[0], 4'h3, 4'h3, 1'b0);
			lock_try(p[0], 4'h3, 4'h4, 1'b1);
			lock_try(p[0], 4'h0, 4'h1, 1'b1);
			lock_try(p[0], 4'hD, 4'hF, 1'b1);
			lock_try(p[0], 4'hE, 4'hF, 1'b0);
			lock_try(p[0], 4'hF, 4'hF, 1'b0);
		end
		// memory fault latched, cleared by w1c, then report only
		apb(1'b1, FCL_ADDR_SETTINGS, 32'h0);
		nvm_pulse();
		#1 chk({30'h0, nvm_fault_latched, irq}, 32'h3);
		rdchk(FCL_ADDR_STATUS, 32'h4, 1'b0);
		apb(1'b1, FCL_ADDR_STATUS, 32'h4);
		@(posedge mclk);
		#1 chk({30'h0, nvm_fault_latched, irq}, 32'h0);
		apb(1'b1, FCL_ADDR_SETTINGS, 32'h1 << FCL_NVM_RESP_BIT);
		apb(1'b1, FCL_ADDR_MASK, 32'h3);
		nvm_pulse();
		#1 chk({30'h0, nvm_fault_latched, irq}, 32'h0);
		rdchk(FCL_ADDR_STATUS, 32'h4, 1'b0);
		apb(1'b1, FCL_ADDR_MASK, 32'h4);
		@(posedge mclk);
		#1 chk({31'h0, irq}, 32'h1);
		apb(1'b1, FCL_ADDR_STATUS, 32'h7);
		rdchk(FCL_ADDR_STATUS, 32'h0, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
